//--- hdl/pcchr_pkg.sv
// Constants and carrier types for the class code and header type registers
package pcchr_pkg;

	// Byte offsets in configuration space
	localparam logic [7:0] FUNCTION_CATEGORY_CODE_OFS = 8'h09;
	localparam logic [7:0] CONFIG_LAYOUT_TYPE_OFS = 8'h0e;

	// Dword holding each register and its lowest byte lane
	localparam logic [5:0] CATEGORY_DWORD = 6'h02;
	localparam logic [5:0] LAYOUT_DWORD = 6'h03;
	localparam int CATEGORY_LANE = 1;
	localparam int LAYOUT_LANE = 2;

	// Field values of the category code
	localparam logic [7:0] BASE_CLASS_VAL = 8'h06; // RULE2
	localparam logic [7:0] SUB_CLASS_VAL = 8'h00; // RULE3
	localparam logic [7:0] PROG_IF_VAL = 8'h00; // RULE4
	localparam logic [23:0] CATEGORY_CODE_VAL =
		{BASE_CLASS_VAL, SUB_CLASS_VAL, PROG_IF_VAL};

	// Fields of the layout type register
	localparam int MULTI_FUNC_BIT = 7;
	localparam logic MULTI_FUNC_VAL = 1'b1; // RULE5
	localparam logic [6:0] LAYOUT_VAL = 7'h00; // RULE6
	localparam logic [7:0] LAYOUT_TYPE_VAL = {MULTI_FUNC_VAL, LAYOUT_VAL};

	// Idle values of the answer
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} pcchr_cfg_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} pcchr_cfg_rsp_t;

endpackage

//--- hdl/pcchr_regs.sv
// Read-only class code and header type registers behind a config port
// Function
// [RULE1] A 24-bit class code at offset 09h is read-only; writes change nothing.
// [RULE2] Bits 23:16 of the class code always read 06h, a bridge device.
// [RULE3] Bits 15:8 of the class code read 00h, a host bridge.
// [RULE4] Bits 7:0 of the class code read 00h, no programming interface.
// [RULE5] An 8-bit header type at offset 0Eh has bit 7 always read as 1.
// [RULE6] Bits 6:0 of the header type read 00h, the type-zero header layout.
// [RULE7] Writes to the header type complete normally and change nothing.
`timescale 1ns/1ns

module pcchr_regs (
	input wire logic clk,
	input wire logic reset,
	input wire logic cke,
	input wire pcchr_pkg::pcchr_cfg_req_t cfg_req,
	output pcchr_pkg::pcchr_cfg_rsp_t cfg_rsp
);
	import pcchr_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACK = 2'b10
	} pcchr_state_t;

	pcchr_state_t state_q, state_d;
	logic [31:0] rdata_q, rdata_d;
	logic ack_q, ack_d;
	logic take;

	////////////////////////////////////////////////////////////////////
	// Read decode; byte lanes not enabled and unmapped dwords give zero

	function automatic logic [31:0] read_dword(input logic [5:0] idx,
		input logic [3:0] be);
		logic [31:0] raw;
		logic [31:0] mask;
		raw = 32'h0000_0000;
		mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		if (idx == CATEGORY_DWORD) begin
			raw[8*CATEGORY_LANE +: 24] = CATEGORY_CODE_VAL; // RULE1
		end else if (idx == LAYOUT_DWORD) begin
			raw[8*LAYOUT_LANE +: 8] = LAYOUT_TYPE_VAL; // RULE5
		end
		return raw & mask;
	endfunction

	////////////////////////////////////////////////////////////////////
	// One request at a time; a request during the answer cycle is ignored

	assign take = cfg_req.valid && (state_q == ST_IDLE);

	always_comb begin
		state_d = state_q;
		ack_d = 1'b0;
		rdata_d = RDATA_RST;
		case (state_q)
			ST_IDLE: begin
				if (take) begin
					state_d = ST_ACK;
					ack_d = 1'b1; // RULE7
					// Writes hold no storage, so every field stays fixed
					if (!cfg_req.write) begin // RULE1 RULE7
						rdata_d = read_dword(cfg_req.addr[7:2], cfg_req.be);
					end
				end
			end
			ST_ACK: begin
				// A request held over this cycle waits for the next one
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Reset drops ack and data so a host never sees a stale answer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= ST_IDLE;
			ack_q <= 1'b0;
			rdata_q <= RDATA_RST;
		end else if (cke) begin
			state_q <= state_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// Both answer fields leave straight from flip-flops
	assign cfg_rsp.ack = ack_q;
	assign cfg_rsp.rdata = rdata_q;

	////////////////////////////////////////////////////////////////////
	// Checks

	// Copy of the request being answered, so checks can look back at it
	pcchr_cfg_req_t req_q, req_d;

	always_comb begin
		req_d = req_q;
		if (take) begin
			req_d = cfg_req;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			req_q <= '0;
		end else if (cke) begin
			req_q <= req_d;
		end
	end

	sequence s_read_cat;
		take && !cfg_req.write && cfg_req.addr[7:2] == CATEGORY_DWORD
			&& cke;
	endsequence

	sequence s_read_lay;
		take && !cfg_req.write && cfg_req.addr[7:2] == LAYOUT_DWORD
			&& cke;
	endsequence

	// One answer cycle, then quiet unless the enable froze the answer
	sequence s_answer_once;
		cfg_rsp.ack ##1 (!cfg_rsp.ack || !$past(cke));
	endsequence

	chk_class_whole: assert property ( // RULE1
		@(posedge clk) disable iff (reset)
		(s_read_cat and (cfg_req.be == 4'hf)) |=>
		cfg_rsp.ack && cfg_rsp.rdata[31:8] == 24'h060000)
		else $error("class code read wrong");

	chk_class_base: assert property ( // RULE2
		@(posedge clk) disable iff (reset)
		(s_read_cat and cfg_req.be[3]) |=>
		cfg_rsp.rdata[31:24] == 8'h06)
		else $error("base class not 06h");

	chk_class_sub: assert property ( // RULE3
		@(posedge clk) disable iff (reset)
		cfg_rsp.ack && !req_q.write && req_q.addr[7:2] == CATEGORY_DWORD
		|-> cfg_rsp.rdata[23:16] == 8'h00)
		else $error("sub-class not 00h");

	chk_class_progif: assert property ( // RULE4
		@(posedge clk) disable iff (reset)
		cfg_rsp.ack && req_q.addr[7:2] == CATEGORY_DWORD
		|-> cfg_rsp.rdata[15:8] == 8'h00)
		else $error("programming interface not 00h");

	chk_hdr_multi: assert property ( // RULE5
		@(posedge clk) disable iff (reset)
		(s_read_lay and cfg_req.be[2]) |=>
		cfg_rsp.rdata[23] == 1'b1)
		else $error("multi-function bit not set");

	chk_hdr_layout: assert property ( // RULE6
		@(posedge clk) disable iff (reset)
		(s_read_lay and cfg_req.be[2]) |=>
		cfg_rsp.rdata[22:16] == 7'h00)
		else $error("layout field not 00h");

	chk_write_done: assert property ( // RULE7
		@(posedge clk) disable iff (reset)
		take && cfg_req.write && cke |=> s_answer_once)
		else $error("write not completed in one cycle");

	chk_write_nodata: assert property ( // RULE1
		@(posedge clk) disable iff (reset)
		cfg_rsp.ack && req_q.write |-> cfg_rsp.rdata == 32'h0)
		else $error("write answer carries data");

	chk_layout_whole: assert property ( // RULE5
		@(posedge clk) disable iff (reset)
		(s_read_lay and (cfg_req.be == 4'hf)) |=>
		cfg_rsp.ack && cfg_rsp.rdata == 32'h0080_0000)
		else $error("header type dword read wrong");

	chk_read_once: assert property ( // RULE1
		@(posedge clk) disable iff (reset)
		s_read_cat |=> s_answer_once)
		else $error("class code read not answered once");

	// A low enable must freeze the answer, not cut it short
	chk_ack_hold: assert property (
		@(posedge clk) disable iff (reset)
		cfg_rsp.ack && !cke |=> cfg_rsp.ack && $stable(cfg_rsp.rdata))
		else $error("answer moved while enable low");

	chk_ack_cause: assert property (
		@(posedge clk) disable iff (reset)
		$rose(cfg_rsp.ack) |-> $past(take) && $past(cke))
		else $error("answer without a taken request");

	chk_idle_quiet: assert property (
		@(posedge clk) disable iff (reset)
		!cfg_rsp.ack |-> cfg_rsp.rdata == 32'h0)
		else $error("read data outside an answer");

	chk_unmapped_zero: assert property (
		@(posedge clk) disable iff (reset)
		cfg_rsp.ack && req_q.addr[7:2] != CATEGORY_DWORD
		&& req_q.addr[7:2] != LAYOUT_DWORD |-> cfg_rsp.rdata == 32'h0)
		else $error("unmapped dword not zero");

	// The revision byte shares the dword but belongs to another block
	chk_rev_zero: assert property (
		@(posedge clk) disable iff (reset)
		cfg_rsp.ack && req_q.addr[7:2] == CATEGORY_DWORD
		|-> cfg_rsp.rdata[7:0] == 8'h00)
		else $error("revision byte not zero");

	// Every byte lane that the request left disabled reads zero
	for (genvar n = 0; n < 4; n++) begin : g_lane_off
		chk_lane_off: assert property (
			@(posedge clk) disable iff (reset)
			cfg_rsp.ack && !req_q.be[n]
			|-> cfg_rsp.rdata[8*n +: 8] == 8'h00)
			else $error("disabled byte lane not zero");
	end

endmodule // pcchr_regs

//--- bench/tb_pcchr_regs.sv
// Self-checking bench for the class code and header type registers
`timescale 1ns/1ns
module tb_pcchr_regs;
	import pcchr_pkg::*;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] exp;
	} pcchr_row_t;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic cke = 1'b1;
	pcchr_cfg_req_t cfg_req = '0;
	pcchr_cfg_rsp_t cfg_rsp;
	int n_errors = 0;
	int comparisons = 0;
	int acks;
	// Write rows carry all-ones data, so any stored bit would show later
	pcchr_row_t rows [0:11] = '{
		'{1'b0, 8'h08, 4'hf, 32'h0600_0000}, '{1'b0, 8'h0b, 4'hf, 32'h0600_0000},
		'{1'b0, 8'h08, 4'h8, 32'h0600_0000}, '{1'b0, 8'h08, 4'h6, 32'h0},
		'{1'b0, 8'h08, 4'h1, 32'h0}, '{1'b1, 8'h08, 4'hf, 32'h0},
		'{1'b0, 8'h08, 4'hf, 32'h0600_0000}, '{1'b0, 8'h0c, 4'hf, 32'h0080_0000},
		'{1'b0, 8'h0e, 4'h4, 32'h0080_0000}, '{1'b1, 8'h0c, 4'hf, 32'h0},
		'{1'b0, 8'h0c, 4'hf, 32'h0080_0000}, '{1'b0, 8'h10, 4'hf, 32'h0}};
	always #25 clk = ~clk;
	pcchr_regs dut (
		.clk(clk),
		.reset(reset),
		.cke(cke),
		.cfg_req(cfg_req),
		.cfg_rsp(cfg_rsp)
	);
	////////////////////////////////////////////////////////////////////////
	task check(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Entered at a falling edge; the answer is due one cycle after taking
	task access(input pcchr_row_t r);
		cfg_req.valid = 1'b1;
		cfg_req.write = r.wr;
		cfg_req.addr = r.addr;
		cfg_req.be = r.be;
		cfg_req.wdata = 32'hffff_ffff;
		@(posedge clk);
		@(negedge clk);
		cfg_req.valid = 1'b0;
		check("ack", 32'h1, {31'h0, cfg_rsp.ack});
		check("rdata", r.exp, cfg_rsp.rdata);
		@(negedge clk);
		check("ack_end", 32'h0, {31'h0, cfg_rsp.ack});
		check("rdata_end", 32'h0, cfg_rsp.rdata);
	endtask
	task report_and_stop;
		if (n_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(negedge clk);
		check("rst_rsp", 32'h0, cfg_rsp.rdata | {31'h0, cfg_rsp.ack});
		reset = 1'b0;
		for (int i = 0; i < 12; i++) begin
			access(rows[i]);
		end
		// A stalled clock enable holds the request off and the answer up
		cfg_req.write = rows[7].wr;
		cfg_req.addr = rows[7].addr;
		cfg_req.be = rows[7].be;
		cfg_req.valid = 1'b1;
		cke = 1'b0;
		repeat (3) @(negedge clk);
		check("frozen_ack", 32'h0, {31'h0, cfg_rsp.ack});
		cke = 1'b1;
		@(negedge clk);
		cfg_req.valid = 1'b0;
		cke = 1'b0;
		check("late_ack", 32'h1, {31'h0, cfg_rsp.ack});
		@(negedge clk);
		check("held_ack", 32'h1, {31'h0, cfg_rsp.ack});
		check("held_rdata", 32'h0080_0000, cfg_rsp.rdata);
		cke = 1'b1;
		@(negedge clk);
		check("held_end", 32'h0, {31'h0, cfg_rsp.ack});
		access(rows[7]);
		// Held valid: taken every second cycle only
		cfg_req.valid = 1'b1;
		acks = 0;
		for (int k = 0; k < 4; k++) begin
			@(negedge clk);
			acks += int'(cfg_rsp.ack === 1'b1);
			check("b2b_ack", (k % 2 == 0) ? 32'h1 : 32'h0,
				{31'h0, cfg_rsp.ack});
			check("b2b_rdata", (k % 2 == 0) ? 32'h0080_0000 : 32'h0,
				cfg_rsp.rdata);
		end
		cfg_req.valid = 1'b0;
		check("b2b_acks", 32'h2, acks);
		// Reset in mid answer clears it at once; the next read is taken
		@(negedge clk);
		cfg_req.valid = 1'b1;
		@(negedge clk);
		check("pre_rst_ack", 32'h1, {31'h0, cfg_rsp.ack});
		cfg_req.valid = 1'b0;
		reset = 1'b1;
		@(negedge clk);
		check("rst_mid", 32'h0, cfg_rsp.rdata | {31'h0, cfg_rsp.ack});
		reset = 1'b0;
		access(rows[0]);
		report_and_stop;
	end
	initial begin
		#(400 * 50);
		n_errors++;
		report_and_stop;
	end
endmodule // tb_pcchr_regs
